//--- rtl/sram_pipe_pkg.sv
// Shared types and constants for the pipelined synchronous SRAM core.
// Assumes a single core clock; all pin-side signals arrive asynchronously.
package sram_pipe_pkg;

  // Array geometry: 128K words of two 9-bit byte lanes
  localparam int ADDR_W = 17;
  localparam int BYTES = 2;
  localparam int BYTE_W = 9;
  localparam int DATA_W = BYTES * BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Burst counter width and burst sequence selector values
  localparam int BURST_W = 2;
  localparam logic BURST_LINEAR = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;

  // Sleep entry and exit latency, counted in clock periods
  localparam int SLEEP_ENTRY_DELAY_CYC = 2;
  localparam int SLEEP_EXIT_DELAY_CYC = 2;

  // Operation carried by a pipeline stage
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_READ = 3'b010,
    OP_WRITE = 3'b100
  } op_t;

  // One sampled snapshot of the memory pins
  typedef struct packed {
    logic cs_n;
    logic cs2_n;
    logic cs_hi;
    logic adv;
    logic rw;
    logic cke_n;
    logic oe_n;
    logic sleep;
    logic mode;
    logic [BYTES-1:0] bw_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
  } pins_t;

  // One pipeline stage
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0] bw_n;
  } stage_t;

endpackage

//--- rtl/sram_pipe.sv
// Pipelined synchronous SRAM core with burst counter, stall and sleep.
// Assumes pins come from an outside controller and are synchronised here.
`timescale 1ns/1ps

module sram_pipe (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [sram_pipe_pkg::ADDR_W-1:0] address,
  input wire logic chip_select_n,
  input wire logic chip_select_second_n,
  input wire logic chip_select_high,
  input wire logic advance_not_load,
  input wire logic read_not_write,
  input wire logic [sram_pipe_pkg::BYTES-1:0] byte_write_strobes_n,
  input wire logic clock_enable_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_mode,
  input wire logic [sram_pipe_pkg::DATA_W-1:0] data_in,
  output logic [sram_pipe_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);

  // Whole control state of the core
  typedef struct packed {
    sram_pipe_pkg::pins_t meta;
    sram_pipe_pkg::pins_t pin;
    sram_pipe_pkg::op_t burst_op;
    logic [sram_pipe_pkg::ADDR_W-1:0] base;
    logic [sram_pipe_pkg::BURST_W-1:0] count;
    sram_pipe_pkg::stage_t s1;
    sram_pipe_pkg::stage_t s2;
    logic hold_v;
    logic [sram_pipe_pkg::ADDR_W-1:0] hold_addr;
    logic [sram_pipe_pkg::DATA_W-1:0] hold_data;
    logic [sram_pipe_pkg::BYTES-1:0] hold_be;
    logic [sram_pipe_pkg::DATA_W-1:0] q;
    logic q_oe;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic commit;
  logic enabled;
  logic selected;
  logic [sram_pipe_pkg::DATA_W-1:0] mem [0:sram_pipe_pkg::DEPTH-1];
  logic [sram_pipe_pkg::DATA_W-1:0] mem_word;

  // Burst address from base, counter and sequence mode
  function automatic logic [sram_pipe_pkg::ADDR_W-1:0] burst_addr(
    input logic [sram_pipe_pkg::ADDR_W-1:0] base,
    input logic [sram_pipe_pkg::BURST_W-1:0] cnt,
    input logic mode
  );
    logic [sram_pipe_pkg::BURST_W-1:0] lo;
    lo = (mode == sram_pipe_pkg::BURST_INTERLEAVED) ?
         (base[sram_pipe_pkg::BURST_W-1:0] ^ cnt) :
         (base[sram_pipe_pkg::BURST_W-1:0] + cnt);
    return {base[sram_pipe_pkg::ADDR_W-1:sram_pipe_pkg::BURST_W], lo};
  endfunction

  // Overlay held write bytes on an array word when addresses match
  function automatic logic [sram_pipe_pkg::DATA_W-1:0] merge(
    input logic [sram_pipe_pkg::DATA_W-1:0] word,
    input logic [sram_pipe_pkg::DATA_W-1:0] held,
    input logic [sram_pipe_pkg::BYTES-1:0] be,
    input logic hit
  );
    logic [sram_pipe_pkg::DATA_W-1:0] r;
    r = word;
    for (int i = 0; i < sram_pipe_pkg::BYTES; i++) begin
      if (hit && be[i]) begin
        r[i*sram_pipe_pkg::BYTE_W +: sram_pipe_pkg::BYTE_W] =
          held[i*sram_pipe_pkg::BYTE_W +: sram_pipe_pkg::BYTE_W];
      end
    end
    return r;
  endfunction

  // Qualifiers of the synchronised pin snapshot
  assign enabled = !st_reg.pin.sleep && !st_reg.pin.cke_n;
  assign selected = !st_reg.pin.cs_n && !st_reg.pin.cs2_n && st_reg.pin.cs_hi;
  assign mem_word = mem[st_reg.s2.addr];

  // Next-state logic: sync, command stage, pipe stage, data stage
  always_comb begin
    st_next = st_reg;
    commit = 1'b0;
    st_next.meta = '{cs_n: chip_select_n, cs2_n: chip_select_second_n,
                     cs_hi: chip_select_high, adv: advance_not_load,
                     rw: read_not_write, cke_n: clock_enable_n,
                     oe_n: output_enable_n, sleep: sleep_request,
                     mode: burst_mode, bw_n: byte_write_strobes_n,
                     addr: address, din: data_in};
    st_next.pin = st_reg.meta;
    if (st_reg.pin.sleep) begin
      // Asleep: pipeline flushed, bus released, pins ignored
      st_next.s1.op = sram_pipe_pkg::OP_IDLE;
      st_next.s2.op = sram_pipe_pkg::OP_IDLE;
      st_next.burst_op = sram_pipe_pkg::OP_IDLE;
      st_next.q_oe = 1'b0;
    end else if (enabled) begin
      // Command stage
      st_next.s1.bw_n = st_reg.pin.bw_n;
      if (!st_reg.pin.adv) begin
        st_next.base = st_reg.pin.addr;
        st_next.count = '0;
        st_next.s1.addr = st_reg.pin.addr;
        if (!selected) begin
          st_next.s1.op = sram_pipe_pkg::OP_IDLE;
        end else if (st_reg.pin.rw) begin
          st_next.s1.op = sram_pipe_pkg::OP_READ;
        end else begin
          st_next.s1.op = sram_pipe_pkg::OP_WRITE;
        end
        st_next.burst_op = st_next.s1.op;
      end else begin
        st_next.count = st_reg.count + 1'b1;
        st_next.s1.op = st_reg.burst_op;
        st_next.s1.addr = burst_addr(st_reg.base, st_next.count, st_reg.pin.mode);
      end
      st_next.s2 = st_reg.s1;
      // Data stage, two edges after the command
      st_next.q_oe = 1'b0;
      unique case (st_reg.s2.op)
        sram_pipe_pkg::OP_READ: begin
          st_next.q = merge(mem_word, st_reg.hold_data, st_reg.hold_be,
                            st_reg.hold_v && st_reg.hold_addr == st_reg.s2.addr);
          st_next.q_oe = !st_reg.pin.oe_n;
        end
        sram_pipe_pkg::OP_WRITE: begin
          if (!(&st_reg.s2.bw_n)) begin
            commit = st_reg.hold_v;
            st_next.hold_v = 1'b1;
            st_next.hold_addr = st_reg.s2.addr;
            st_next.hold_data = st_reg.pin.din;
            st_next.hold_be = ~st_reg.s2.bw_n;
          end
        end
        sram_pipe_pkg::OP_IDLE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // State register; a stall keeps every field except the meta and pin synchroniser stages
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.s1.op <= sram_pipe_pkg::OP_IDLE;
      st_reg.s2.op <= sram_pipe_pkg::OP_IDLE;
      st_reg.burst_op <= sram_pipe_pkg::OP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Late write: the held word is retired into the array on the next write that enables a byte
  always_ff @(posedge core_clk) begin
    if (commit) begin
      for (int i = 0; i < sram_pipe_pkg::BYTES; i++) begin
        if (st_reg.hold_be[i]) begin
          mem[st_reg.hold_addr][i*sram_pipe_pkg::BYTE_W +: sram_pipe_pkg::BYTE_W] <=
            st_reg.hold_data[i*sram_pipe_pkg::BYTE_W +: sram_pipe_pkg::BYTE_W];
        end
      end
    end
  end

  // Data bus straight from flops
  assign data_out = st_reg.q;
  assign data_oe = st_reg.q_oe;

  // Checks; the sleep lag bounds are local so the delay ranges stay plain
  localparam int SLEEP_IN_MAX = sram_pipe_pkg::SLEEP_ENTRY_DELAY_CYC;
  localparam int SLEEP_OUT_MAX = sram_pipe_pkg::SLEEP_EXIT_DELAY_CYC;

  property p_sleep_entry;
    @(posedge core_clk) disable iff (!nrst)
      $rose(sleep_request) |-> ##[1:SLEEP_IN_MAX] st_reg.pin.sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry too slow");

  property p_sleep_exit;
    @(posedge core_clk) disable iff (!nrst)
      $fell(sleep_request) |-> ##[1:SLEEP_OUT_MAX] !st_reg.pin.sleep;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit too slow");

  property p_sleep_idle;
    @(posedge core_clk) disable iff (!nrst)
      st_reg.pin.sleep |=> st_reg.s1.op == sram_pipe_pkg::OP_IDLE &&
                           st_reg.s2.op == sram_pipe_pkg::OP_IDLE && !data_oe;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("active while asleep");

  property p_load_read;
    @(posedge core_clk) disable iff (!nrst)
      enabled && !st_reg.pin.adv && selected && st_reg.pin.rw |=>
        st_reg.s1.op == sram_pipe_pkg::OP_READ && st_reg.s1.addr == $past(st_reg.pin.addr);
  endproperty
  a_load_read: assert property (p_load_read) else $error("read not loaded");

  property p_load_write;
    @(posedge core_clk) disable iff (!nrst)
      enabled && !st_reg.pin.adv && selected && !st_reg.pin.rw |=>
        st_reg.s1.op == sram_pipe_pkg::OP_WRITE ##1
        (!$past(enabled) || st_reg.s2.op == sram_pipe_pkg::OP_WRITE);
  endproperty
  a_load_write: assert property (p_load_write) else $error("write not loaded");

  property p_deselect;
    @(posedge core_clk) disable iff (!nrst)
      enabled && !st_reg.pin.adv && !selected |=> st_reg.s1.op == sram_pipe_pkg::OP_IDLE;
  endproperty
  a_deselect: assert property (p_deselect) else $error("unselected load taken");

  property p_stall;
    @(posedge core_clk) disable iff (!nrst)
      !st_reg.pin.sleep && st_reg.pin.cke_n |=>
        $stable(st_reg.s1) && $stable(st_reg.s2) && $stable(data_oe) && !$past(commit);
  endproperty
  a_stall: assert property (p_stall) else $error("stall changed state");

  property p_write_quiet;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.s2.op == sram_pipe_pkg::OP_WRITE |=> !data_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");

  property p_read_drive;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.s2.op == sram_pipe_pkg::OP_READ && !st_reg.pin.oe_n |=> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  property p_burst_step;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.pin.adv |=> st_reg.s1.op == $past(st_reg.burst_op) &&
        st_reg.count == $past(st_reg.count) + 2'h1 &&
        st_reg.s1.addr == burst_addr($past(st_reg.base), st_reg.count, $past(st_reg.pin.mode));
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst step wrong");

  // Fourth continue lands back on the loaded address in either order
  property p_burst_wrap;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.pin.adv && st_reg.count == 2'h3 |=>
        st_reg.s1.addr == $past(st_reg.base);
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst did not wrap");

  // First continue: linear adds one, interleaved flips the lowest bit
  property p_first_step;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.pin.adv && st_reg.count == 2'h0 |=>
        st_reg.s1.addr[sram_pipe_pkg::BURST_W-1:0] == ($past(st_reg.pin.mode) ?
          ($past(st_reg.base[sram_pipe_pkg::BURST_W-1:0]) ^ 2'h1) :
          ($past(st_reg.base[sram_pipe_pkg::BURST_W-1:0]) + 2'h1));
  endproperty
  a_first_step: assert property (p_first_step) else $error("first step out of order");

  property p_coherent;
    @(posedge core_clk) disable iff (!nrst)
      enabled && st_reg.s2.op == sram_pipe_pkg::OP_READ && st_reg.hold_v &&
      st_reg.hold_addr == st_reg.s2.addr && (&st_reg.hold_be) |=>
        data_out == $past(st_reg.hold_data);
  endproperty
  a_coherent: assert property (p_coherent) else $error("stale read data");

  property p_abort;
    @(posedge core_clk) disable iff (!nrst)
      st_reg.s2.op == sram_pipe_pkg::OP_WRITE && (&st_reg.s2.bw_n) |=>
        $stable(st_reg.hold_data) && $stable(st_reg.hold_v) && !$past(commit);
  endproperty
  a_abort: assert property (p_abort) else $error("abort wrote data");

  // Asleep: held write word and array stay untouched
  property p_sleep_hold;
    @(posedge core_clk) disable iff (!nrst)
      st_reg.pin.sleep |=>
        $stable(st_reg.hold_v) && $stable(st_reg.hold_data) && !$past(commit);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("write taken while asleep");

  // Main scenarios
  c_read: cover property (@(posedge core_clk) disable iff (!nrst) $rose(data_oe));
  c_write: cover property (@(posedge core_clk) disable iff (!nrst) commit);
  c_wrap: cover property (@(posedge core_clk) disable iff (!nrst)
    enabled && st_reg.pin.adv && st_reg.count == 2'h3);
  c_sleep: cover property (@(posedge core_clk) disable iff (!nrst) $fell(st_reg.pin.sleep));
  c_stall: cover property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.pin.sleep && st_reg.pin.cke_n && data_oe);

endmodule // sram_pipe

//--- test/sram_ctrl_model.sv
// Controller model: one pin snapshot per clock, write data two cycles after its command.
// Assumes the bench calls drive or idle every cycle so the write-data pipe advances.
`timescale 1ns/1ps

module sram_ctrl_model (
  input wire logic core_clk,
  output sram_pipe_pkg::pins_t pins
);
  logic [1:0] wv = 2'h0;
  logic [sram_pipe_pkg::DATA_W-1:0] wd0 = '0;
  logic [sram_pipe_pkg::DATA_W-1:0] wd1 = '0;

  // Deselected and awake until the first command
  initial pins = '{cs_n: 1'b1, default: '0};

  // One clock of pins; misc is {clock enable, output enable, burst mode, sleep}
  task automatic drive(input logic adv, input logic rw, input logic [2:0] sel,
      input logic [16:0] a, input logic [1:0] bw, input logic [17:0] d, input logic [3:0] misc);
    @(posedge core_clk);
    {pins.cs_n, pins.cs2_n, pins.cs_hi} <= sel;
    pins.adv <= adv;
    pins.rw <= rw;
    pins.addr <= a;
    pins.bw_n <= bw;
    {pins.cke_n, pins.oe_n, pins.mode, pins.sleep} <= misc;
    wv <= {wv[0], !adv && !rw && !misc[3]};
    wd0 <= d;
    wd1 <= wd0;
    // A released data bus reads back as the inverse of its last value
    pins.din <= wv[1] ? wd1 : ~pins.din;
  endtask

  // Deselect cycles only, so no write can start during sleep recovery
  task automatic idle(input int n);
    repeat (n) drive(1'b0, 1'b1, 3'h5, ~pins.addr, 2'h3, wd0, 4'h0);
  endtask
endmodule // sram_ctrl_model

//--- test/pipelined_sram_cycle_and_sleep_bench.sv
// Self-checking bench for the pipelined SRAM core.
// Assumes the controller model drives every pin; outputs are read 1 ns after an edge.
`timescale 1ns/1ps

module pipelined_sram_cycle_and_sleep_bench;
  localparam logic [2:0] SEL = 3'h1;
  localparam logic [16:0] A = 17'h00A30;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  sram_pipe_pkg::pins_t p;
  logic [17:0] data_out;
  logic data_oe;
  logic [17:0] exp_a;
  int n_mismatch = 0;
  int total_checks = 0;

  // Clock of 4 ns
  always #2 core_clk = ~core_clk;

  sram_ctrl_model ctl (.core_clk, .pins(p));

  sram_pipe dut (
    .core_clk, .nrst, .address(p.addr), .chip_select_n(p.cs_n),
    .chip_select_second_n(p.cs2_n), .chip_select_high(p.cs_hi), .advance_not_load(p.adv),
    .read_not_write(p.rw), .byte_write_strobes_n(p.bw_n), .clock_enable_n(p.cke_n),
    .output_enable_n(p.oe_n), .sleep_request(p.sleep), .burst_mode(p.mode),
    .data_in(p.din), .data_out, .data_oe
  );

  // Compare and count
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle n cycles, then sample just after the last edge
  task automatic look(input int n);
    ctl.idle(n);
    #1;
  endtask

  task automatic rd(input logic [16:0] a, input logic [3:0] misc);
    ctl.drive(1'b0, 1'b1, SEL, a, 2'h3, 18'h0, misc);
  endtask

  task automatic wr(input logic [16:0] a, input logic [1:0] bw, input logic [17:0] d);
    ctl.drive(1'b0, 1'b0, SEL, a, bw, d, 4'h0);
  endtask

  // Full write, lane-0 write and abort to one word, read straight behind them
  task automatic t_coherent();
    wr(A, 2'h0, 18'h1F0F0);
    wr(A, 2'h2, 18'h2A5A5);
    wr(A, 2'h3, 18'h3FFFF);
    rd(A, 4'h0);
    exp_a = (18'h1F0F0 & 18'h3FE00) | (18'h2A5A5 & 18'h001FF);
    look(4);
    check({17'h0, data_oe}, 18'h0);
    look(1);
    check(data_out, exp_a);
    check({17'h0, data_oe}, 18'h1);
    $display("coherent write and read done");
  endtask

  // Bursts of five from word 5 in both orders; the fifth access wraps to the first
  task automatic t_burst();
    logic [1:0] ofs;
    for (int i = 4; i < 8; i++) wr(17'(i), 2'h0, 18'(i) + 18'h00300);
    ctl.idle(2);
    for (int m = 0; m < 2; m++) begin
      rd(17'h5, {2'h0, 1'(m), 1'b0});
      repeat (4) ctl.drive(1'b1, 1'b1, SEL, 17'h0, 2'h3, 18'h0, {2'h0, 1'(m), 1'b0});
      for (int k = 0; k < 5; k++) begin
        look(1);
        ofs = (m == 0) ? 2'(1 + k) : 2'(1 ^ k);
        check(data_out, 18'h00304 + 18'(ofs));
      end
    end
    $display("burst orders done");
  endtask

  // Each chip select deasserted alone leaves the bus released
  task automatic t_deselect();
    logic [2:0] sel [3] = '{3'h5, 3'h3, 3'h0};
    for (int i = 0; i < 3; i++) begin
      ctl.drive(1'b0, 1'b1, sel[i], A, 2'h3, 18'h0, 4'h0);
      look(5);
      check({17'h0, data_oe}, 18'h0);
    end
    $display("deselect done");
  endtask

  // A stall before the answer delays it; a stall after it keeps the bus driven
  task automatic t_stall();
    rd(A, 4'h0);
    repeat (3) ctl.drive(1'b1, 1'b1, SEL, A, 2'h3, 18'h0, 4'h8);
    look(4);
    check({17'h0, data_oe}, 18'h0);
    look(1);
    check(data_out, exp_a);
    // Read answer appears, then the next two edges are stalled
    rd(A, 4'h0);
    ctl.idle(2);
    repeat (2) ctl.drive(1'b1, 1'b1, SEL, A, 2'h3, 18'h0, 4'h8);
    look(2);
    check({17'h0, data_oe}, 18'h1);
    check(data_out, exp_a);
    look(1);
    check({17'h0, data_oe}, 18'h1);
    $display("stall done");
  endtask

  // Reads and writes under sleep change nothing and never drive the bus
  task automatic t_sleep();
    ctl.idle(6);
    for (int i = 0; i < 6; i++) begin
      ctl.drive(1'b0, i[0], i < 4 ? SEL : 3'h5, A, 2'h0, 18'h0, 4'h1);
      #1;
      check({17'h0, data_oe}, 18'h0);
    end
    for (int i = 0; i < 3; i++) begin
      look(1);
      check({17'h0, data_oe}, 18'h0);
    end
    rd(A, 4'h0);
    look(5);
    check(data_out, exp_a);
    $display("sleep done");
  endtask

  // Count summary and verdict
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    ctl.idle(2);
    t_coherent();
    t_burst();
    t_deselect();
    t_stall();
    t_sleep();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    $display("Error at %0t: run timed out", $time);
    stop_test();
  end
endmodule // pipelined_sram_cycle_and_sleep_bench
